// file: core/ics_sequencer.sv
/*
 * Instruction cycle sequencer: four-phase timing, fetch/execute pipeline,
 * branch flush, quarter-rate clock output, page and bank selection.
 * Assumes program memory returns the word combinationally for the held
 * address and the decoder supplies branch target and result data.
 */
// Notes on behaviour
// RULE1: Oscillator divided by four into phases.
// RULE2: Program counter steps at phase_one each cycle.
// RULE3: Fetched word latched at phase_four.
// RULE4: Latched word executed across phases two-four.
// RULE5: Operand read phase_two, result write phase_four.
// RULE6: Fetch overlaps execute, one per cycle.
// RULE7: Program counter change costs two cycles.
// RULE8: Quarter-rate clock out in RC/internal modes.
// RULE9: Page select bit picks program page.
// RULE10: Indirect pointer picks data bank.
// RULE11: Addresses wrap in 1K; start at zero.
// RULE12: After reset first cycle fetches only.
// RULE13: Flushed word becomes no-operation.
`default_nettype none
module ics_sequencer (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic external_rc_mode_i,
    input wire logic internal_oscillator_mode_i,
    input wire logic quarter_rate_clock_out_enable_i,
    input wire logic [ics_pkg::INSN_W-1:0] pmem_rdata_i,
    input wire logic pc_change_i,
    input wire logic [ics_pkg::PC_W-1:0] pc_target_i,
    input wire logic program_page_select_i,
    input wire logic [ics_pkg::DATA_W-1:0] indirect_pointer_i,
    input wire logic indirect_access_i,
    input wire logic [ics_pkg::DIRECT_W-1:0] direct_addr_i,
    input wire logic dest_write_i,
    input wire logic [ics_pkg::DATA_W-1:0] result_i,
    output ics_pkg::ics_phase_t phase_o,
    output ics_pkg::ics_pmem_req_t pmem_req_o,
    output ics_pkg::ics_exec_t exec_o,
    output ics_pkg::ics_dmem_req_t dmem_req_o,
    output logic quarter_rate_clock_out_o
);
    // Pipeline state; reset values arrive through each _d term except the dmem_d addr and wdata fields
    ics_pkg::ics_phase_t phase_q, phase_d;
    logic [ics_pkg::PC_W-1:0] program_counter_q, program_counter_d;
    logic [ics_pkg::INSN_W-1:0] fetch_q, fetch_d;
    logic fetch_valid_q, fetch_valid_d;
    logic [ics_pkg::INSN_W-1:0] instruction_latch_q, instruction_latch_d;
    logic exec_valid_q, exec_valid_d;
    logic [ics_pkg::PC_W-1:0] fetch_addr_q, fetch_addr_d;
    logic quarter_rate_clock_out_q, quarter_rate_clock_out_d;
    ics_pkg::ics_dmem_req_t dmem_q, dmem_d;

    // Wrap any address into the implemented 1K space
    function automatic logic [ics_pkg::PC_W-1:0] wrap_pc(input logic [ics_pkg::PC_W:0] a);
        wrap_pc = a[ics_pkg::PC_W-1:0];
    endfunction

    // Next phase in the four-step walk; all four codes are legal
    function automatic ics_pkg::ics_phase_t next_phase(input ics_pkg::ics_phase_t p);
        next_phase = ics_pkg::PH_ONE;
        unique case (p)
            ics_pkg::PH_ONE: next_phase = ics_pkg::PH_TWO;
            ics_pkg::PH_TWO: next_phase = ics_pkg::PH_THREE;
            ics_pkg::PH_THREE: next_phase = ics_pkg::PH_FOUR;
            ics_pkg::PH_FOUR: next_phase = ics_pkg::PH_ONE;
        endcase
    endfunction

    // Phase decodes shared by the datapath and the checks
    wire is_p1 = (phase_q == ics_pkg::PH_ONE);
    wire is_p2 = (phase_q == ics_pkg::PH_TWO);
    wire is_p3 = (phase_q == ics_pkg::PH_THREE);
    wire is_p4 = (phase_q == ics_pkg::PH_FOUR);
    wire branch_taken = is_p4 && exec_valid_q && pc_change_i;

    // Phase walk: 1,2,3,4 then back to 1
    assign phase_d = srst_i ? ics_pkg::PH_ONE : next_phase(phase_q); // RULE1 RULE12

    // Target keeps its low 9 bits; page select supplies bit 9
    wire [ics_pkg::PC_W-1:0] paged_target =
        {program_page_select_i, pc_target_i[ics_pkg::PAGE_BIT-1:0]}; // RULE9

    // Program counter steps at phase_one; branch loads target at phase_four
    assign program_counter_d = srst_i ? ics_pkg::RESET_VECTOR
        : branch_taken ? paged_target
        : is_p1 ? wrap_pc({1'b0, program_counter_q} + 11'h001) // RULE2 RULE11
        : program_counter_q;

    // Fetch address is the count before its phase_one step, so the reset
    // vector and a branch target are fetched themselves, not skipped
    assign fetch_addr_d = srst_i ? ics_pkg::RESET_VECTOR
        : is_p1 ? program_counter_q // RULE3 RULE11
        : fetch_addr_q;

    // Fetch register captures memory at phase_four, flushed on branch
    assign fetch_d = srst_i ? ics_pkg::NOP_WORD
                   : (is_p4 ? pmem_rdata_i : fetch_q); // RULE3 RULE6
    assign fetch_valid_d = srst_i ? 1'b0
                         : (is_p4 ? !branch_taken : fetch_valid_q); // RULE7 RULE12

    // Execute stage loads the latched word at phase_one
    assign instruction_latch_d = srst_i ? ics_pkg::NOP_WORD
        : is_p1 ? (fetch_valid_q ? fetch_q : ics_pkg::NOP_WORD) // RULE4 RULE13
        : instruction_latch_q;
    assign exec_valid_d = srst_i ? 1'b0 : (is_p1 ? fetch_valid_q : exec_valid_q);

    // Bank from pointer bits, direct address fills the low part
    wire [ics_pkg::DADDR_W-1:0] data_addr = indirect_access_i
        ? indirect_pointer_i[ics_pkg::DADDR_W-1:0]
        : {indirect_pointer_i[ics_pkg::BANK_LSB +: ics_pkg::BANK_W], direct_addr_i}; // RULE10

    // Read strobe in phase_two, write strobe in phase_four
    assign dmem_d.addr = data_addr;
    assign dmem_d.rd = !srst_i && exec_valid_d && (phase_d == ics_pkg::PH_TWO); // RULE5
    assign dmem_d.wr = !srst_i && exec_valid_d && dest_write_i
                     && (phase_d == ics_pkg::PH_FOUR); // RULE5
    assign dmem_d.wdata = result_i;

    // High across phases three/four gives a 50% duty quarter-rate clock
    wire quarter_rate_clock_out_on = (external_rc_mode_i || internal_oscillator_mode_i) && quarter_rate_clock_out_enable_i;
    assign quarter_rate_clock_out_d = !srst_i && quarter_rate_clock_out_on
                    && (phase_d == ics_pkg::PH_THREE || phase_d == ics_pkg::PH_FOUR); // RULE8

    // State registers
    always_ff @(posedge clock_i) begin
        phase_q <= phase_d;
        program_counter_q <= program_counter_d;
        fetch_q <= fetch_d;
        fetch_valid_q <= fetch_valid_d;
        fetch_addr_q <= fetch_addr_d;
        instruction_latch_q <= instruction_latch_d;
        exec_valid_q <= exec_valid_d;
        dmem_q <= dmem_d;
        quarter_rate_clock_out_q <= quarter_rate_clock_out_d;
    end

    // Outputs; memory address held through the whole cycle
    assign phase_o = phase_q;
    assign pmem_req_o.addr = fetch_addr_q;
    assign pmem_req_o.rd = is_p4;
    assign exec_o.word = instruction_latch_q;
    assign exec_o.valid = exec_valid_q;
    assign dmem_req_o = dmem_q;
    assign quarter_rate_clock_out_o = quarter_rate_clock_out_q;

    // Checks; sequences name the multi-step behaviours
    sequence s_p1_after_p4;
        is_p4 ##1 is_p1;
    endsequence

    // Clock out falls at the cycle boundary and stays low through phase_two
    sequence s_quarter_rate_clock_out_low;
        !quarter_rate_clock_out_o ##1 !quarter_rate_clock_out_o;
    endsequence

    // One empty execute cycle, then the refetched target runs
    sequence s_one_bubble;
        ##2 !exec_valid_q ##4 exec_valid_q;
    endsequence

    // Phase sequencing
    a_phase_wrap: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p4 |=> is_p1) else $error("phase did not wrap"); // RULE1
    a_phase_cycle: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p1 |-> ##4 is_p1) else $error("cycle not four phases"); // RULE1

    // Program counter and fetch address
    a_pc_step: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p1 |=> program_counter_q == wrap_pc({1'b0, $past(program_counter_q)} + 11'h001))
        else $error("pc did not step"); // RULE2 RULE11
    a_pc_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p2 |=> $stable(program_counter_q)) else $error("pc moved mid cycle"); // RULE2
    a_pc_wrap: assert property (@(posedge clock_i) disable iff (srst_i)
        (is_p1 && program_counter_q == {ics_pkg::PC_W{1'b1}})
        |=> program_counter_q == ics_pkg::RESET_VECTOR) else $error("pc did not wrap"); // RULE11
    a_fetch_addr: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p1 |=> pmem_req_o.addr == $past(program_counter_q)) else $error("bad fetch addr"); // RULE3
    a_fetch_latch: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p4 |=> fetch_q == $past(pmem_rdata_i)) else $error("word not latched"); // RULE3

    // Execute stage
    a_exec_load: assert property (@(posedge clock_i) disable iff (srst_i)
        s_p1_after_p4 |-> ##1 instruction_latch_q == $past(fetch_q) || !exec_valid_q)
        else $error("exec not loaded"); // RULE4 RULE6
    a_nop_idle: assert property (@(posedge clock_i) disable iff (srst_i)
        !exec_valid_q |-> instruction_latch_q == ics_pkg::NOP_WORD) else $error("idle not nop"); // RULE13
    a_access_valid: assert property (@(posedge clock_i) disable iff (srst_i)
        (dmem_req_o.rd || dmem_req_o.wr) |-> exec_valid_q) else $error("access when idle"); // RULE12

    // Data memory strobes
    a_read_phase: assert property (@(posedge clock_i) disable iff (srst_i)
        dmem_req_o.rd |-> phase_q == ics_pkg::PH_TWO) else $error("read off phase"); // RULE5
    a_read_once: assert property (@(posedge clock_i) disable iff (srst_i)
        dmem_req_o.rd |=> !dmem_req_o.rd) else $error("read too long"); // RULE5
    a_write_phase: assert property (@(posedge clock_i) disable iff (srst_i)
        dmem_req_o.wr |-> phase_q == ics_pkg::PH_FOUR) else $error("write off phase"); // RULE5
    a_write_once: assert property (@(posedge clock_i) disable iff (srst_i)
        dmem_req_o.wr |=> !dmem_req_o.wr) else $error("write too long"); // RULE5

    // Branch flush and refetch
    a_branch_flush: assert property (@(posedge clock_i) disable iff (srst_i)
        branch_taken |-> ##2 (!exec_valid_q && instruction_latch_q == ics_pkg::NOP_WORD))
        else $error("flush missing"); // RULE7 RULE13
    a_branch_target: assert property (@(posedge clock_i) disable iff (srst_i)
        branch_taken |=> program_counter_q == $past(paged_target)) else $error("bad target"); // RULE9
    a_one_bubble: assert property (@(posedge clock_i) disable iff (srst_i)
        branch_taken |-> s_one_bubble) else $error("branch not two cycles"); // RULE7
    a_refill_addr: assert property (@(posedge clock_i) disable iff (srst_i)
        branch_taken |=> ##1 (pmem_req_o.addr == $past(paged_target, 2)))
        else $error("target not fetched"); // RULE7 RULE9

    // Quarter-rate clock; the enables may change at any phase
    a_quarter_rate_clock_out_rate: assert property (@(posedge clock_i) disable iff (srst_i)
        is_p4 |=> s_quarter_rate_clock_out_low) else $error("clock out rate"); // RULE8
    a_quarter_rate_clock_out_high: assert property (@(posedge clock_i) disable iff (srst_i)
        (quarter_rate_clock_out_on && (is_p2 || is_p3)) |=> quarter_rate_clock_out_o)
        else $error("clock out not high"); // RULE8
    a_quarter_rate_clock_out_off: assert property (@(posedge clock_i) disable iff (srst_i)
        !quarter_rate_clock_out_on |=> !quarter_rate_clock_out_o) else $error("clock out not off"); // RULE8

    // Reset state
    a_reset_start: assert property (@(posedge clock_i)
        srst_i |=> (is_p1 && program_counter_q == ics_pkg::RESET_VECTOR && !exec_valid_q
                    && !fetch_valid_q)) else $error("bad reset state"); // RULE11 RULE12
endmodule
`default_nettype wire

// file: inc/ics_pkg.sv
/*
 * Package for the instruction cycle sequencer: widths, phase encoding,
 * reset values and the small struct carriers shared by the core.
 * Assumes a single clock domain at 200 MHz with a synchronous reset.
 */
`default_nettype none
package ics_pkg;
    localparam int PC_W = 10;
    localparam int INSN_W = 12;
    localparam int DADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PHASES = 4;
    localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
    localparam logic [PC_W-1:0] PAGE_SIZE_WORDS = 10'h200;
    localparam int PAGE_BIT = 9;
    localparam int BANK_LSB = 5;
    localparam int BANK_W = 2;
    localparam int DIRECT_W = 5;
    localparam logic [INSN_W-1:0] NOP_WORD = 12'h000;

    // Phase counter, one state per oscillator cycle
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } ics_phase_t;

    // Instruction memory request
    typedef struct packed {
        logic [PC_W-1:0] addr;
        logic rd;
    } ics_pmem_req_t;

    // Data memory request
    typedef struct packed {
        logic [DADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } ics_dmem_req_t;

    // Execution stage view for the decoder
    typedef struct packed {
        logic [INSN_W-1:0] word;
        logic valid;
    } ics_exec_t;
endpackage
`default_nettype wire

// file: tb/ics_partner.sv
/* Partner model: program memory and data register file.
   Assumes program words are read combinationally at phase_four. */
`default_nettype none
module ics_partner (
    input wire logic clock_i,
    input wire ics_pkg::ics_pmem_req_t pmem_req_i,
    input wire ics_pkg::ics_dmem_req_t dmem_req_i,
    output logic [ics_pkg::INSN_W-1:0] pmem_rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [ics_pkg::INSN_W-1:0] word;
    logic [ics_pkg::DATA_W-1:0] file_q [128];
    // Word valid only under the read strobe, else junk so late use shows
    assign word = {pmem_req_i.addr[1:0], pmem_req_i.addr} ^ 12'h5a3;
    assign pmem_rdata_o = pmem_req_i.rd ? word : ~word;
    // Register file keeps destination writes
    always_ff @(posedge clock_i) begin
        if (dmem_req_i.wr) begin
            file_q[dmem_req_i.addr] <= dmem_req_i.wdata;
        end
    end
endmodule
`default_nettype wire

// file: tb/test_instruction_cycle_sequencer.sv
/* Bench for the sequencer: random decoder inputs, a reference of the
   executed instruction stream, checks at every phase.
   Assumes the partner model answers program reads combinationally. */
`default_nettype none
module test_instruction_cycle_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i, srst_i, rc, io, en, pcc, pps, ind, dw, vld, flush, qclk;
    logic [11:0] rdata;
    logic [9:0] tgt, exp_addr;
    logic [7:0] ptr, res;
    logic [4:0] dadr;
    logic [31:0] r, r2, seed;
    int fails, cmp_count, ph, icy;
    ics_pkg::ics_phase_t phase;
    ics_pkg::ics_pmem_req_t preq;
    ics_pkg::ics_exec_t ex;
    ics_pkg::ics_dmem_req_t dreq;
    ics_sequencer u_ics_sequencer (.clock_i(clock_i), .srst_i(srst_i),
        .external_rc_mode_i(rc), .internal_oscillator_mode_i(io),
        .quarter_rate_clock_out_enable_i(en), .pmem_rdata_i(rdata), .pc_change_i(pcc),
        .pc_target_i(tgt), .program_page_select_i(pps),
        .indirect_pointer_i(ptr), .indirect_access_i(ind),
        .direct_addr_i(dadr), .dest_write_i(dw), .result_i(res),
        .phase_o(phase), .pmem_req_o(preq), .exec_o(ex), .dmem_req_o(dreq),
        .quarter_rate_clock_out_o(qclk));
    ics_partner u_ics_partner (.clock_i(clock_i), .pmem_req_i(preq),
        .dmem_req_i(dreq), .pmem_rdata_o(rdata));
    // Reference program image, same pattern as the partner holds
    function automatic logic [11:0] rom(logic [9:0] a);
        return {a[1:0], a} ^ 12'h5a3;
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // One pass per clock; branches are random, plus a forced jump to the top word
    initial begin
        seed = 32'hbb0b;
        srst_i = 1'b1;
        {rc, io, en, pcc, pps, ind, dw, tgt, ptr, res, dadr} = '0;
        {fails, cmp_count} = '0;
        {vld, flush} = 2'b00;
        exp_addr = 10'h000;
        repeat (5) @(posedge clock_i);
        #1 srst_i = 1'b0;
        for (int n = 0; n < 4800; n++) begin
            ph = n % 4;
            icy = n / 4;
            chk(phase, ph);
            chk(preq.rd, ph == 3);
            chk(qclk, (rc | io) & en & (ph >= 2));
            if (ph == 0) begin
                vld = icy > 0 && !flush;
                flush = 1'b0;
                r = $random(seed);
                r2 = $random(seed);
                {dw, dadr, ind, ptr, pps, tgt, pcc, en, io, rc} =
                    {r[31:6], r[5:3] == 3'h0, r[2:0]};
                res = r2[7:0];
                if (icy > 17 && icy < 27) pcc = icy == 20;
                if (icy == 20) {pps, tgt} = {1'b1, 10'h1ff};
            end
            if (vld) chk(dreq.rd, ph == 1);
            if (vld && ph == 1) chk(dreq.addr, ind ? ptr[6:0] : {ptr[6:5], dadr});
            if (ph == 2) begin
                chk(ex.valid, vld);
                chk(ex.word, vld ? rom(exp_addr) : ics_pkg::NOP_WORD);
                if (vld) exp_addr++;
            end
            if (ph == 3) chk(preq.addr, exp_addr);
            if (vld && ph == 3) begin
                chk(dreq.wr, dw);
                if (dw) chk(dreq.wdata, res);
                if (pcc) {flush, exp_addr} = {1'b1, pps, tgt[8:0]};
            end
            @(posedge clock_i);
            #1;
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
